/* File: rtl/pcg_consts.svh */
// offsets, field positions, reset values and counts of the clock gating block
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH
`define PCG_ADDR_W        12
`define PCG_OFF_RUN0      12'h100
`define PCG_OFF_RUN1      12'h104
`define PCG_OFF_SLP0      12'h110
`define PCG_OFF_SLP1      12'h114
`define PCG_OFF_DSL0      12'h120
`define PCG_OFF_DSL1      12'h124
`define PCG_OFF_CLK_CFG   12'h060
`define PCG_OFF_PWR       12'h1F0
`define PCG_OFF_IRQ_STAT  12'h1F4
`define PCG_OFF_IRQ_MASK  12'h1F8
`define PCG_AUTO_GATING_BIT 27
`define PCG_G0_WMASK      32'h0111_0308
`define PCG_G0_IMPL       32'h0111_0308
`define PCG_G1_WMASK      32'h0307_1013
`define PCG_RESET_VAL     32'h0000_0000
`define PCG_CLK_CFG_RESET 32'h0000_0000
`define PCG_BIT_CAN       24
`define PCG_BIT_PWM       20
`define PCG_BIT_ADC       16
`define PCG_BIT_WDOG      3
`define PCG_RATE_LSB      8
`define PCG_RATE_MAX      2'h1
`define PCG_BIT_CMP1      25
`define PCG_BIT_CMP0      24
`define PCG_BIT_TMR2      18
`define PCG_BIT_TMR1      17
`define PCG_BIT_TMR0      16
`define PCG_BIT_TWI       12
`define PCG_BIT_SSI       4
`define PCG_BIT_SER1      1
`define PCG_BIT_SER0      0
`define PCG_NUM_UNITS     13
`define PCG_IRQ_W         3
`endif

/* File: rtl/pcg_pkg.sv */
// types of the clock gating block
package pcg_pkg;
    typedef enum logic [2:0]
    {
        PCG_PWR_RUN   = 3'b001,
        PCG_PWR_SLEEP = 3'b010,
        PCG_PWR_DEEP  = 3'b100
    } pcg_pwr_t;
endpackage

/* File: rtl/pcg_gate_cell.sv */
// glitch-free clock gate: enable latched while the clock is low
`timescale 1ns/1ns
module pcg_gate_cell
(
    input  wire logic clock,
    input  wire logic enable,
    output wire logic gated_clock
);
    logic en_latch;

    always_latch
    begin
        if (!clock)
        begin
            en_latch <= enable;
        end
    end

    assign gated_clock = clock & en_latch;
endmodule

/* File: rtl/pcg_unit_map.sv */
// maps the two applied gating words onto one enable per peripheral
`timescale 1ns/1ns
`include "pcg_consts.svh"
module pcg_unit_map
(
    input  wire logic [31:0]                 group0,
    input  wire logic [31:0]                 group1,
    output logic      [`PCG_NUM_UNITS-1:0]   unit_en
);
    // unit order: can,pwm,adc,wdog,cmp1,cmp0,tmr2,tmr1,tmr0,twi,ssi,ser1,ser0
    always_comb
    begin
        unit_en = {group0[`PCG_BIT_CAN], group0[`PCG_BIT_PWM], group0[`PCG_BIT_ADC],
                   group0[`PCG_BIT_WDOG], group1[`PCG_BIT_CMP1], group1[`PCG_BIT_CMP0],
                   group1[`PCG_BIT_TMR2], group1[`PCG_BIT_TMR1], group1[`PCG_BIT_TMR0],
                   group1[`PCG_BIT_TWI], group1[`PCG_BIT_SSI], group1[`PCG_BIT_SER1],
                   group1[`PCG_BIT_SER0]};
    end
endmodule

/* File: rtl/pcg_top.sv */
// peripheral clock gating controller with per-power-state register sets
`timescale 1ns/1ns
`include "pcg_consts.svh"
module pcg_top
    import pcg_pkg::*;
#(
    parameter int NUM_UNITS = `PCG_NUM_UNITS
)
(
    input  wire logic                    clock,
    input  wire logic                    rst,
    input  wire logic [`PCG_ADDR_W-1:0]  reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [31:0]             reg_rdata,
    input  wire logic                    sleep_req,
    input  wire logic                    deep_req,
    input  wire logic [NUM_UNITS-1:0]    periph_sel,
    input  wire logic                    periph_acc,
    output logic                         bus_fault,
    output logic      [NUM_UNITS-1:0]    unit_enable,
    output logic      [NUM_UNITS-1:0]    unit_clock,
    output logic      [1:0]              converter_rate_select,
    output logic                         irq
);
    // register sets: index 0 run, 1 sleep, 2 deep-sleep
    logic [31:0] g0_q [3];
    logic [31:0] g0_d [3];
    logic [31:0] g1_q [3];
    logic [31:0] g1_d [3];
    logic [31:0] clk_cfg_q, clk_cfg_d;
    logic [`PCG_IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d;
    logic [31:0] rdata_d;
    logic        irq_d;
    // synchronised power requests and peripheral access and select inputs
    logic [1:0]  slp_s, dsl_s;
    logic        acc_s1, acc_s2;
    logic [NUM_UNITS-1:0] sel_s1, sel_s2;
    pcg_pwr_t    pwr_q, pwr_d;
    logic [31:0] app0_q, app0_d, app1_q, app1_d;
    logic [NUM_UNITS-1:0] en_map, en_q;
    logic [1:0]  rate_q, rate_d;
    logic        fault_q, fault_d;
    logic        pwr_evt, fault_evt;

    // caps a written rate field at the supported maximum
    function automatic logic [31:0] cap_rate(input logic [31:0] v);
        logic [31:0] r;
        r = v & `PCG_G0_WMASK;
        if (r[`PCG_RATE_LSB +: 2] > `PCG_RATE_MAX)
        begin
            r[`PCG_RATE_LSB +: 2] = `PCG_RATE_MAX;
        end
        return r;
    endfunction

    function automatic logic hit(input logic [`PCG_ADDR_W-1:0] a,
                                 input logic [`PCG_ADDR_W-1:0] off);
        return a == off;
    endfunction

    localparam logic [`PCG_ADDR_W-1:0] OFF0 [3] = '{`PCG_OFF_RUN0, `PCG_OFF_SLP0, `PCG_OFF_DSL0};
    localparam logic [`PCG_ADDR_W-1:0] OFF1 [3] = '{`PCG_OFF_RUN1, `PCG_OFF_SLP1, `PCG_OFF_DSL1};

    // register writes: three identical sets per group
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            g0_d[i] = g0_q[i];
            g1_d[i] = g1_q[i];
            if (reg_wr && hit(reg_addr, OFF0[i]))
            begin
                g0_d[i] = cap_rate(reg_wdata);
            end
            if (reg_wr && hit(reg_addr, OFF1[i]))
            begin
                g1_d[i] = reg_wdata & `PCG_G1_WMASK;
            end
        end
        clk_cfg_d = clk_cfg_q;
        if (reg_wr && hit(reg_addr, `PCG_OFF_CLK_CFG))
        begin
            clk_cfg_d = reg_wdata;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 3; i++)
            begin
                g0_q[i] <= `PCG_RESET_VAL;
                g1_q[i] <= `PCG_RESET_VAL;
            end
            clk_cfg_q <= `PCG_CLK_CFG_RESET;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                g0_q[i] <= g0_d[i];
                g1_q[i] <= g1_d[i];
            end
            clk_cfg_q <= clk_cfg_d;
        end
    end

    // input synchronisers
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            slp_s  <= 2'h0;
            dsl_s  <= 2'h0;
            acc_s1 <= 1'b0;
            acc_s2 <= 1'b0;
            sel_s1 <= '0;
            sel_s2 <= '0;
        end
        else
        begin
            slp_s  <= {slp_s[0], sleep_req};
            dsl_s  <= {dsl_s[0], deep_req};
            acc_s1 <= periph_acc;
            acc_s2 <= acc_s1;
            sel_s1 <= periph_sel;
            sel_s2 <= sel_s1;
        end
    end

    // power state and applied gating set
    always_comb
    begin
        if (dsl_s[1])
        begin
            pwr_d = PCG_PWR_DEEP;
        end
        else if (slp_s[1])
        begin
            pwr_d = PCG_PWR_SLEEP;
        end
        else
        begin
            pwr_d = PCG_PWR_RUN;
        end
        app0_d = g0_d[0];
        app1_d = g1_d[0];
        if (clk_cfg_d[`PCG_AUTO_GATING_BIT])
        begin
            unique case (pwr_d)
                PCG_PWR_RUN:
                begin
                    app0_d = g0_d[0];
                    app1_d = g1_d[0];
                end
                PCG_PWR_SLEEP:
                begin
                    app0_d = g0_d[1];
                    app1_d = g1_d[1];
                end
                PCG_PWR_DEEP:
                begin
                    app0_d = g0_d[2];
                    app1_d = g1_d[2];
                end
            endcase
        end
        rate_d = app0_d[`PCG_RATE_LSB +: 2];
    end

    pcg_unit_map u_map
    (
        .group0  (app0_q),
        .group1  (app1_q),
        .unit_en (en_map)
    );

    // fault when the addressed peripheral has its clock stopped
    always_comb
    begin
        fault_d   = acc_s2 && ((sel_s2 & ~en_q) != '0);
        pwr_evt   = pwr_q != pwr_d;
        fault_evt = fault_d;
        stat_d    = stat_q;
        mask_d    = mask_q;
        if (reg_rd && hit(reg_addr, `PCG_OFF_IRQ_STAT))
        begin
            stat_d = '0;
        end
        if (reg_wr && hit(reg_addr, `PCG_OFF_IRQ_MASK))
        begin
            mask_d = reg_wdata[`PCG_IRQ_W-1:0];
        end
        // set wins over the read clear
        stat_d = stat_d | {acc_s2 && !fault_d, fault_evt, pwr_evt};
        irq_d  = (stat_d & mask_d) != '0;
        rdata_d = 32'h0000_0000;
        for (int i = 0; i < 3; i++)
        begin
            if (hit(reg_addr, OFF0[i]))
            begin
                rdata_d = g0_q[i];
            end
            if (hit(reg_addr, OFF1[i]))
            begin
                rdata_d = g1_q[i];
            end
        end
        if (hit(reg_addr, `PCG_OFF_CLK_CFG))
        begin
            rdata_d = clk_cfg_q;
        end
        if (hit(reg_addr, `PCG_OFF_PWR))
        begin
            rdata_d = {29'h0, pwr_q};
        end
        if (hit(reg_addr, `PCG_OFF_IRQ_STAT))
        begin
            rdata_d = {29'h0, stat_q};
        end
        if (hit(reg_addr, `PCG_OFF_IRQ_MASK))
        begin
            rdata_d = {29'h0, mask_q};
        end
        if (!reg_rd)
        begin
            rdata_d = 32'h0000_0000;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pwr_q     <= PCG_PWR_RUN;
            app0_q    <= `PCG_RESET_VAL;
            app1_q    <= `PCG_RESET_VAL;
            en_q      <= '0;
            rate_q    <= 2'h0;
            fault_q   <= 1'b0;
            stat_q    <= '0;
            mask_q    <= '0;
            irq       <= 1'b0;
            reg_rdata <= 32'h0000_0000;
        end
        else
        begin
            pwr_q     <= pwr_d;
            app0_q    <= app0_d;
            app1_q    <= app1_d;
            en_q      <= en_map;
            rate_q    <= rate_d;
            fault_q   <= fault_d;
            stat_q    <= stat_d;
            mask_q    <= mask_d;
            irq       <= irq_d;
            reg_rdata <= rdata_d;
        end
    end

    assign unit_enable           = en_q;
    assign converter_rate_select = rate_q;
    assign bus_fault             = fault_q;

    // one glitch-free gate per peripheral
    genvar gi;
    generate
        for (gi = 0; gi < NUM_UNITS; gi++)
        begin : g_gate
            pcg_gate_cell u_cell
            (
                .clock       (clock),
                .enable      (en_q[gi]),
                .gated_clock (unit_clock[gi])
            );
        end
    endgenerate

    a_rate_capped: assert property (@(posedge clock) disable iff (rst)
        rate_q <= `PCG_RATE_MAX) else $error("rate above maximum");
    a_fault_gated: assert property (@(posedge clock) disable iff (rst)
        (acc_s2 && (sel_s2 & ~en_q) != '0) |=> bus_fault) else $error("no fault");
    a_fault_open: assert property (@(posedge clock) disable iff (rst)
        (acc_s2 && (sel_s2 & ~en_q) == '0) |=> !bus_fault) else $error("bad fault");
    a_run_applied: assert property (@(posedge clock) disable iff (rst)
        !clk_cfg_q[`PCG_AUTO_GATING_BIT] |-> app1_q == g1_q[0]) else $error("run set not used");
    a_deep_applied: assert property (@(posedge clock) disable iff (rst)
        (clk_cfg_q[`PCG_AUTO_GATING_BIT] && pwr_q == PCG_PWR_DEEP) |-> app0_q == g0_q[2])
        else $error("deep set not used");
    a_enable_follows: assert property (@(posedge clock) disable iff (rst)
        ##1 (en_q[NUM_UNITS-1] == $past(app0_q[`PCG_BIT_CAN])
            && en_q[0] == $past(app1_q[`PCG_BIT_SER0]))) else $error("enable lags");
    a_g0_reserved: assert property (@(posedge clock) disable iff (rst)
        (g0_q[0] & ~`PCG_G0_WMASK) == '0) else $error("reserved bit set");
    a_g1_reserved: assert property (@(posedge clock) disable iff (rst)
        (g1_q[2] & ~`PCG_G1_WMASK) == '0) else $error("reserved bit set");
    a_irq_level: assert property (@(posedge clock) disable iff (rst)
        irq == ((stat_q & mask_q) != '0)) else $error("irq mismatch");
    c_fault: cover property (@(posedge clock) disable iff (rst) bus_fault);
    c_deep: cover property (@(posedge clock) disable iff (rst) pwr_q == PCG_PWR_DEEP);
    c_irq: cover property (@(posedge clock) disable iff (rst) irq);
endmodule

/* File: bench/peripheral_clock_gating_tb.sv */
// self-checking testbench of the peripheral clock gating controller
`timescale 1ns/1ns
`include "pcg_consts.svh"
`define CHK(got, exp) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("unexpected at %0t: got %h exp %h", $time, got, exp); \
        end \
    end
module peripheral_clock_gating_tb;
    import pcg_pkg::*;
    logic        clock;
    logic        rst;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        sleep_req;
    logic        deep_req;
    logic [12:0] periph_sel;
    logic        periph_acc;
    logic        bus_fault;
    logic [12:0] unit_enable;
    logic [12:0] unit_clock;
    logic [1:0]  converter_rate_select;
    logic        irq;
    int          miscompares;
    int          compares;
    logic [31:0] d;
    logic [11:0] offs [6];
    // unit index -> gating bit; units 0..8 live in group 1, 9..12 in group 0
    int          bits [13];

    pcg_top DUT
    (
        .clock                 (clock),
        .rst                   (rst),
        .reg_addr              (reg_addr),
        .reg_wdata             (reg_wdata),
        .reg_wr                (reg_wr),
        .reg_rd                (reg_rd),
        .reg_rdata             (reg_rdata),
        .sleep_req             (sleep_req),
        .deep_req              (deep_req),
        .periph_sel            (periph_sel),
        .periph_acc            (periph_acc),
        .bus_fault             (bus_fault),
        .unit_enable           (unit_enable),
        .unit_clock            (unit_clock),
        .converter_rate_select (converter_rate_select),
        .irq                   (irq)
    );

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // one access pulse, then count fault cycles in the window after it
    task automatic acc(input logic [12:0] s, input int exp);
        int n;
        n = 0;
        @(posedge clock);
        periph_sel <= s;
        periph_acc <= 1'b1;
        @(posedge clock);
        periph_acc <= 1'b0;
        repeat (6)
        begin
            @(posedge clock);
            #1;
            if (bus_fault !== 1'b0)
                n++;
        end
        `CHK(n, exp)
    endtask

    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #400000;
        miscompares++;
        stop_test();
    end

    initial
    begin
        rst = 1'b1; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0; reg_rd = 1'b0;
        sleep_req = 1'b0; deep_req = 1'b0; periph_sel = '0; periph_acc = 1'b0;
        miscompares = 0;
        compares = 0;
        offs = '{`PCG_OFF_RUN0, `PCG_OFF_SLP0, `PCG_OFF_DSL0,
                 `PCG_OFF_RUN1, `PCG_OFF_SLP1, `PCG_OFF_DSL1};
        bits = '{0, 1, 4, 12, 16, 17, 18, 24, 25, 3, 16, 20, 24};
        repeat (4) @(posedge clock);
        rst <= 1'b0;

        for (int i = 0; i < 6; i++)
        begin
            rd(offs[i], d);
            `CHK(d, 32'h0000_0000)
        end
        `CHK(unit_enable, 13'h0000)
        $display("test reset values done");

        for (int i = 0; i < 6; i++)
        begin
            wr(offs[i], 32'hFFFF_FFFF);
            rd(offs[i], d);
            if (i < 3)
                `CHK(d, 32'h0111_0108)
            else
                `CHK(d, 32'h0307_1013)
        end
        settle(3);
        `CHK(unit_enable, 13'h1FFF)
        `CHK(converter_rate_select, 2'h1)
        $display("test register access done");

        for (int v = 0; v < 4; v++)
        begin
            wr(`PCG_OFF_RUN0, 32'(v) << 8);
            rd(`PCG_OFF_RUN0, d);
            `CHK(d, (v == 0) ? 32'h0 : 32'h100)
            settle(2);
            `CHK(converter_rate_select, (v == 0) ? 2'h0 : 2'h1)
        end
        $display("test converter rate done");

        for (int i = 0; i < 13; i++)
        begin
            wr(`PCG_OFF_RUN0, (i >= 9) ? (32'h1 << bits[i]) : 32'h0);
            wr(`PCG_OFF_RUN1, (i < 9) ? (32'h1 << bits[i]) : 32'h0);
            settle(3);
            `CHK(unit_enable, 13'h1 << i)
            `CHK(unit_clock, 13'h1 << i)
            acc(13'h1 << i, 0);
            acc(13'h1 << ((i + 1) % 13), 1);
        end
        $display("test unit gating and faults done");

        wr(`PCG_OFF_RUN1, 32'h0);
        wr(`PCG_OFF_RUN0, 32'h0010_0000);
        wr(`PCG_OFF_SLP0, 32'h0000_0008);
        wr(`PCG_OFF_DSL0, 32'h0100_0000);
        wr(`PCG_OFF_SLP1, 32'h0);
        wr(`PCG_OFF_DSL1, 32'h0);
        sleep_req <= 1'b1;
        settle(8);
        `CHK(unit_enable, 13'h0800)
        rd(`PCG_OFF_PWR, d);
        `CHK(d, 32'h2)
        wr(`PCG_OFF_CLK_CFG, 32'h1 << `PCG_AUTO_GATING_BIT);
        settle(4);
        `CHK(unit_enable, 13'h0200)
        deep_req <= 1'b1;
        settle(8);
        `CHK(unit_enable, 13'h1000)
        rd(`PCG_OFF_PWR, d);
        `CHK(d, 32'h4)
        sleep_req <= 1'b0;
        deep_req  <= 1'b0;
        settle(8);
        `CHK(unit_enable, 13'h0800)
        $display("test power states done");

        wr(`PCG_OFF_IRQ_MASK, 32'h0);
        rd(`PCG_OFF_IRQ_STAT, d);
        `CHK(d, 32'h7)
        acc(13'h0001, 1);
        `CHK(irq, 1'b0)
        rd(`PCG_OFF_IRQ_STAT, d);
        `CHK(d, 32'h2)
        rd(`PCG_OFF_IRQ_STAT, d);
        `CHK(d, 32'h0)
        wr(`PCG_OFF_IRQ_MASK, 32'h2);
        acc(13'h0002, 1);
        `CHK(irq, 1'b1)
        rd(`PCG_OFF_IRQ_STAT, d);
        settle(2);
        `CHK(irq, 1'b0)
        acc(13'h0800, 0);
        rd(`PCG_OFF_IRQ_STAT, d);
        `CHK(d, 32'h4)
        $display("test interrupt done");

        rd(`PCG_OFF_RUN0, d);
        wr(`PCG_OFF_RUN0, d | (32'h1 << `PCG_BIT_WDOG));
        rd(`PCG_OFF_RUN0, d);
        `CHK(d, 32'h0010_0008)

        wr(12'h200, 32'hFFFF_FFFF);
        rd(12'h200, d);
        `CHK(d, 32'h0)
        settle(1);
        `CHK(reg_rdata, 32'h0)
        @(posedge clock);
        rst <= 1'b1;
        settle(2);
        rst <= 1'b0;
        rd(`PCG_OFF_RUN0, d);
        `CHK(d, 32'h0)
        `CHK(unit_enable, 13'h0000)
        $display("test unmapped and second reset done");
        stop_test();
    end
endmodule
